// ---- logic/vas_top.sv ----
// Purpose: Voice audio serial port, always clock master, PCM or I2S, APB registers.
// Assumes: audio_clk is the free running internal audio clock (8192 kHz nominal).
// Notes: Configuration is taken by the audio side only while the port is disabled, except the master clock enable.
//
// The APB slave port and the address map are this design's own decisions.
module vas_top
	import vas_pkg::*;
#(
	parameter int CLK_KHZ = AUD_CLK_KHZ
) (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Audio link.
	input wire logic audio_clk,
	output logic bit_clk_out,
	output logic frame_sync_out,
	output logic master_clk_out,
	output logic shared_pad_audio_out,
	output logic shared_pad_audio_out_oe_n,
	input wire logic shared_pad_audio_in,
	output logic shared_pad_audio_in_oe_n,
	// Power management.
	output logic sleep_block
);
	if (CLK_KHZ % (2 * BCLK_KHZ[NUM_RATES-1]) != 0) begin : g_chk
		$error("audio clock must be an even multiple of the fastest bit clock");
	end

	// ---------------- APB side ----------------
	logic [9:0] ctrl;
	logic [1:0] gpio;
	logic [15:0] tx_data;
	logic [15:0] tx_stage;
	logic [15:0] rx_data;
	logic rx_ready;
	logic tx_pending;
	logic nb_ph;
	logic [2:0] ft_sync;
	logic [1:0] gi_sync;
	logic frame_tog;
	logic [15:0] rx_word;
	logic acc;
	logic wr;
	logic rd;
	logic fev;
	logic take;

	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign fev = ft_sync[2] ^ ft_sync[1];
	assign take = !(ctrl[CT_NB] && !ctrl[CT_I2S]) || !nb_ph;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (paddr == OFF_CTRL) begin
				prdata[9:0] <= ctrl;
			end else if (paddr == OFF_STAT) begin
				prdata[ST_RX] <= rx_ready;
				prdata[ST_TXP] <= tx_pending;
				prdata[ST_SLEEPBLK] <= sleep_block;
				prdata[ST_NBPH] <= nb_ph;
			end else if (paddr == OFF_TX) begin
				prdata[15:0] <= tx_data;
			end else if (paddr == OFF_RX) begin
				prdata[15:0] <= rx_data;
			end else if (paddr == OFF_GPIO) begin
				prdata[1:0] <= gpio;
				prdata[GP_IN] <= gi_sync[1] && !ctrl[CT_PAD];
			end else begin
				pslverr <= 1'b1;
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Configuration fields are frozen while enabled; only the enable and master clock bits may change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RST;
		end else if (wr && paddr == OFF_CTRL) begin
			if (ctrl[CT_EN]) begin
				ctrl[CT_EN] <= pwdata[CT_EN];
				ctrl[CT_MCLK] <= pwdata[CT_MCLK];
			end else begin
				ctrl <= pwdata[9:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio <= GPIO_RST;
		end else if (wr && paddr == OFF_GPIO && !ctrl[CT_PAD]) begin
			gpio <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ft_sync <= 3'h0;
			gi_sync <= 2'h0;
		end else begin
			ft_sync <= {ft_sync[1:0], frame_tog};
			gi_sync <= {gi_sync[0], shared_pad_audio_in};
		end
	end

	// A new write wins over consumption by the frame in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data <= 16'h0;
			tx_pending <= 1'b0;
			tx_stage <= 16'h0;
		end else begin
			if (wr && paddr == OFF_TX) begin
				tx_data <= pwdata[15:0];
			end
			if (wr && paddr == OFF_TX) begin
				tx_pending <= 1'b1;
			end else if (fev && take) begin
				tx_pending <= 1'b0;
			end
			// The stage changes just after a frame start, far from the next read.
			if (fev && take) begin
				tx_stage <= tx_data;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data <= 16'h0;
			rx_ready <= 1'b0;
			nb_ph <= 1'b0;
		end else begin
			if (!ctrl[CT_EN]) begin
				nb_ph <= 1'b0;
			end else if (fev) begin
				nb_ph <= ~nb_ph;
			end
			if (fev && take) begin
				rx_data <= rx_word;
			end
			if (fev && take) begin
				rx_ready <= 1'b1;
			end else if (rd && paddr == OFF_RX) begin
				rx_ready <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_block <= 1'b0;
		end else begin
			sleep_block <= ctrl[CT_EN] && !ctrl[CT_GATED];
		end
	end

	// ---------------- Audio clock side ----------------
	logic [1:0] ars;
	logic arst_n;
	logic [4:0] lv0;
	logic [4:0] lv1;
	logic en_a;
	logic pad_a;
	logic gout_a;
	logic goe_a;
	logic mck_a;
	logic [1:0] ds;
	logic cfg_i2s;
	logic cfg_gated;
	logic [7:0] cfg_div;
	logic [7:0] cfg_last;
	logic [7:0] cfg_half;
	logic [2:0] code;
	logic [7:0] cnt;
	logic ph;
	logic first;
	logic [7:0] bit_cnt;
	logic [7:0] next_k;
	logic tick;
	logic rise;
	logic fall;
	logic in_data;
	logic [15:0] sh;
	logic [15:0] rsh;
	logic [1:0] fp;
	logic [1:0] lp;
	logic [7:0] last_data;

	function automatic logic [2:0] rate_code(input logic i2s, input logic r8,
		input logic [1:0] sel);
		logic [2:0] c;
		c = 3'h0;
		if (i2s) begin
			c = r8 ? 3'h0 : 3'h1;
		end else if (r8) begin
			case (sel)
				2'h0: c = 3'h0;
				2'h1: c = 3'h1;
				default: c = 3'h3;
			endcase
		end else begin
			case (sel)
				2'h0: c = 3'h0;
				2'h1: c = 3'h1;
				2'h2: c = 3'h2;
				default: c = 3'h4;
			endcase
		end
		return c;
	endfunction

	function automatic logic [7:0] half_period(input logic [2:0] c);
		return 8'(CLK_KHZ / (2 * BCLK_KHZ[c]));
	endfunction

	// PCM frames are always 16 kHz long; I2S frames follow the chosen rate.
	function automatic logic [7:0] frame_last(input logic i2s, input logic r8,
		input logic [2:0] c);
		int fk;
		fk = (i2s && r8) ? NB_KHZ : FRAME_KHZ;
		return 8'(BCLK_KHZ[c] / fk - 1);
	endfunction

	assign code = rate_code(ctrl[CT_I2S], ctrl[CT_RATE8], ctrl[CT_BSEL +: 2]);

	always_ff @(posedge audio_clk or negedge presetn) begin
		if (!presetn) begin
			ars <= 2'h0;
		end else begin
			ars <= {ars[0], 1'b1};
		end
	end
	assign arst_n = ars[1];

	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			lv0 <= 5'h0;
			lv1 <= 5'h0;
			ds <= 2'h0;
		end else begin
			lv0 <= {ctrl[CT_MCLK], gpio[GP_OE], gpio[GP_OUT], ctrl[CT_PAD], ctrl[CT_EN]};
			lv1 <= lv0;
			ds <= {ds[0], shared_pad_audio_in};
		end
	end
	assign en_a = lv1[0];
	assign pad_a = lv1[1];
	assign gout_a = lv1[2];
	assign goe_a = lv1[3];
	assign mck_a = lv1[4];

	// Settings are copied each cycle while idle, so they are settled when enable lands.
	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_i2s <= 1'b0;
			cfg_gated <= 1'b0;
			cfg_div <= 8'h1;
			cfg_last <= 8'h0;
			cfg_half <= 8'h0;
		end else if (!en_a) begin
			cfg_i2s <= ctrl[CT_I2S];
			cfg_gated <= ctrl[CT_GATED];
			cfg_div <= half_period(code);
			cfg_last <= frame_last(ctrl[CT_I2S], ctrl[CT_RATE8], code);
			cfg_half <= 8'((frame_last(ctrl[CT_I2S], ctrl[CT_RATE8], code) + 1) / 2);
		end
	end

	assign tick = en_a && (cnt == cfg_div - 8'h1);
	assign rise = tick && !ph;
	assign fall = tick && ph;
	assign next_k = (first || bit_cnt == cfg_last) ? 8'h0 : bit_cnt + 8'h1;
	assign in_data = cfg_i2s ? (next_k <= 8'(SAMPLE_W)) : (next_k < 8'(SAMPLE_W));
	assign last_data = cfg_i2s ? 8'(SAMPLE_W) : 8'(SAMPLE_W - 1);

	// Equal count per phase keeps the duty cycle exactly half.
	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 8'h0;
			ph <= 1'b0;
			bit_clk_out <= 1'b0;
		end else if (!en_a) begin
			cnt <= 8'h0;
			ph <= 1'b0;
			bit_clk_out <= 1'b0;
		end else if (tick) begin
			cnt <= 8'h0;
			ph <= ~ph;
			bit_clk_out <= !ph && !(cfg_gated && !cfg_i2s && next_k >= 8'(GATE_BITS));
		end else begin
			cnt <= cnt + 8'h1;
		end
	end

	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			first <= 1'b1;
			bit_cnt <= 8'h0;
			frame_sync_out <= 1'b0;
			frame_tog <= 1'b0;
			sh <= 16'h0;
			shared_pad_audio_out <= 1'b0;
		end else if (!en_a) begin
			first <= 1'b1;
			bit_cnt <= 8'h0;
			frame_sync_out <= 1'b0;
			sh <= 16'h0;
			shared_pad_audio_out <= pad_a ? 1'b0 : gout_a;
		end else if (rise) begin
			first <= 1'b0;
			bit_cnt <= next_k;
			if (cfg_i2s) begin
				frame_sync_out <= next_k >= cfg_half;
			end else begin
				frame_sync_out <= next_k < 8'(PCM_FS_BITS);
			end
			if (next_k == 8'h0) begin
				frame_tog <= ~frame_tog;
				if (cfg_i2s) begin
					sh <= tx_stage;
				end else begin
					sh <= {tx_stage[14:0], 1'b0};
				end
			end else if (in_data) begin
				sh <= {sh[14:0], 1'b0};
			end
			if (!pad_a) begin
				shared_pad_audio_out <= gout_a;
			end else if (next_k == 8'h0) begin
				shared_pad_audio_out <= cfg_i2s ? 1'b0 : tx_stage[15];
			end else begin
				shared_pad_audio_out <= in_data && sh[15];
			end
		end else if (!pad_a) begin
			shared_pad_audio_out <= gout_a;
		end
	end

	// The falling edge is seen two cycles late through the pad synchroniser.
	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			fp <= 2'h0;
			lp <= 2'h0;
			rsh <= 16'h0;
			rx_word <= 16'h0;
		end else begin
			fp <= {fp[0], fall};
			lp <= {lp[0], fall && bit_cnt == last_data};
			if (fp[1]) begin
				rsh <= {rsh[14:0], ds[1]};
			end
			if (lp[1]) begin
				rx_word <= {rsh[14:0], ds[1]};
			end
		end
	end

	always_ff @(posedge audio_clk or negedge arst_n) begin
		if (!arst_n) begin
			master_clk_out <= 1'b0;
			shared_pad_audio_out_oe_n <= 1'b1;
			shared_pad_audio_in_oe_n <= 1'b1;
		end else begin
			master_clk_out <= en_a && mck_a && !master_clk_out;
			shared_pad_audio_out_oe_n <= pad_a ? 1'b0 : !goe_a;
			shared_pad_audio_in_oe_n <= 1'b1;
		end
	end
endmodule

// ---- logic/vas_pkg.sv ----
// Purpose: Shared constants of the voice audio serial master.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Bit clock rates are in kHz; the audio clock divides down to them.
package vas_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_TX = 8'h08;
	localparam logic [7:0] OFF_RX = 8'h0c;
	localparam logic [7:0] OFF_GPIO = 8'h10;
	// Control fields.
	localparam int CT_EN = 0;
	localparam int CT_I2S = 1;
	localparam int CT_RATE8 = 2;
	localparam int CT_BSEL = 4;
	localparam int CT_NB = 6;
	localparam int CT_GATED = 7;
	localparam int CT_MCLK = 8;
	localparam int CT_PAD = 9;
	localparam logic [9:0] CTRL_RST = 10'h000;
	// Status fields.
	localparam int ST_RX = 0;
	localparam int ST_TXP = 1;
	localparam int ST_SLEEPBLK = 2;
	localparam int ST_NBPH = 3;
	// Pad register fields.
	localparam int GP_OUT = 0;
	localparam int GP_OE = 1;
	localparam int GP_IN = 8;
	localparam logic [1:0] GPIO_RST = 2'h0;
	// Link timing.
	localparam int AUD_CLK_KHZ = 8192;
	localparam int FRAME_KHZ = 16;
	localparam int NB_KHZ = 8;
	localparam int SAMPLE_W = 16;
	localparam int PCM_FS_BITS = 16;
	localparam int GATE_BITS = 32;
	localparam int NUM_RATES = 5;
	localparam int BCLK_KHZ [NUM_RATES] = '{256, 512, 1024, 2048, 4096};
endpackage

// ---- dv/vas_chk.sv ----
// Purpose: Pin level checks of the voice audio serial port.
// Assumes: Bound to vas_top; audio_clk clocks the link side.
// Notes: The clock gap bound covers the slowest bit clock plus enable sync.
module vas_chk (
	// APB side.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Link side.
	input wire logic audio_clk,
	input wire logic bit_clk_out,
	input wire logic frame_sync_out,
	input wire logic master_clk_out,
	input wire logic shared_pad_audio_in_oe_n,
	input wire logic sleep_block
);
	logic [7:0] gap;
	always_ff @(posedge audio_clk or negedge presetn) begin
		if (!presetn)
			gap <= 8'h00;
		else if (!sleep_block || $changed(bit_clk_out))
			gap <= 8'h00;
		else if (gap != 8'hff)
			gap <= gap + 8'h01;
	end
	ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready) else $error("late ready");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("ready too long");
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready) else $error("error without ready");
	err_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> prdata == 32'h0) else $error("error read data not zero");
	in_only_a: assert property (@(posedge audio_clk) disable iff (!presetn)
		shared_pad_audio_in_oe_n) else $error("input pad driven");
	sync_edge_a: assert property (@(posedge audio_clk) disable iff (!presetn)
		$changed(frame_sync_out) |-> $rose(bit_clk_out) || !bit_clk_out && !frame_sync_out)
		else $error("sync moved off clock rise");
	mclk_half_a: assert property (@(posedge audio_clk) disable iff (!presetn)
		master_clk_out |=> !master_clk_out) else $error("master clock not half rate");
	sleep_clock_a: assert property (@(posedge audio_clk) disable iff (!presetn)
		gap < 8'd40) else $error("bit clock stalled while sleep blocked");
endmodule

bind vas_top vas_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .audio_clk(audio_clk),
	.bit_clk_out(bit_clk_out), .frame_sync_out(frame_sync_out),
	.master_clk_out(master_clk_out), .sleep_block(sleep_block),
	.shared_pad_audio_in_oe_n(shared_pad_audio_in_oe_n));

// ---- dv/vas_codec.sv ----
// Purpose: Behavioural voice codec, clock slave of the port.
// Assumes: Frame starts where the sync is first seen high.
// Notes: Outside its slot the codec toggles its data line every bit.
module vas_codec #(
	parameter logic [15:0] PATTERN = 16'h3c5a
) (
	// Clock and sync from the port.
	input wire logic bit_clk,
	input wire logic frame_sync,
	// Data lines.
	input wire logic data_from_port,
	output logic data_to_port,
	// Last sample heard.
	output logic [15:0] heard
);
	timeunit 1ns;
	timeprecision 1ps;
	logic seen;
	logic [15:0] shift;
	int tx_bit = 99;
	int rx_bit = 99;
	initial begin
		data_to_port = 1'b0;
		seen = 1'b0;
		heard = 16'h0;
	end
	// Launch just after the rise, once this bit's sync has settled.
	always @(posedge bit_clk) begin
		#1;
		tx_bit = (frame_sync && !seen) ? 0 : tx_bit + 1;
		data_to_port = (tx_bit < 16) ? PATTERN[15 - tx_bit] : ~data_to_port;
	end
	always @(negedge bit_clk) begin
		rx_bit = (frame_sync && !seen) ? 0 : rx_bit + 1;
		seen = frame_sync;
		if (rx_bit < 16)
			shift[15 - rx_bit] = data_from_port;
		if (rx_bit == 15)
			heard = shift;
	end
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench of the voice audio serial port.
// Assumes: Codec model on the link; audio clock period 125 ns.
// Notes: Link timing is measured in audio clock periods.
module testbench
	import vas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic audio_clk = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, bclk, fs, mclk, dout, dout_oe_n, din, din_oe_n, sleep;
	logic [15:0] heard;
	int mismatches = 0;
	int compares = 0;
	int mck = 0;
	int bck = 0;
	localparam logic [31:0] CFGS [9] = '{32'h01, 32'h11, 32'h21, 32'h31, 32'h05, 32'h15,
		32'h25, 32'h07, 32'h03};
	localparam int BPS [9] = '{32, 16, 8, 2, 32, 16, 4, 32, 16};
	always #12.5 pclk = ~pclk;
	initial #3.1 forever #62.5 audio_clk = ~audio_clk;
	always @(posedge mclk) mck++;
	always @(posedge bclk) bck++;
	vas_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .audio_clk(audio_clk), .bit_clk_out(bclk),
		.frame_sync_out(fs), .master_clk_out(mclk), .shared_pad_audio_out(dout),
		.shared_pad_audio_out_oe_n(dout_oe_n), .shared_pad_audio_in(din),
		.shared_pad_audio_in_oe_n(din_oe_n), .sleep_block(sleep));
	vas_codec codec (.bit_clk(bclk), .frame_sync(fs), .data_from_port(dout),
		.data_to_port(din), .heard(heard));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [31:0] v);
		apb(1'b1, OFF_CTRL, 32'h0);
		// The link side reloads its settings only once it has seen the port disabled.
		repeat (4) @(posedge audio_clk);
		apb(1'b1, OFF_CTRL, v);
	endtask
	function automatic logic [31:0] ac(input realtime d);
		return 32'(int'(d / 125.0));
	endfunction
	task automatic regs_scn;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h14, 32'hffffffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, OFF_GPIO, 32'h3);
		repeat (4) @(posedge audio_clk);
		chk({30'h0, dout_oe_n, dout}, 32'h1);
	endtask
	task automatic rate_scn(input logic [31:0] ctrl, input int bp);
		realtime t0, t1, t2;
		int frame, hi;
		frame = ctrl[CT_I2S] ? 32 * bp : 512;
		hi = ctrl[CT_I2S] ? frame / 2 : 16 * bp;
		cfg(ctrl);
		@(posedge bclk) t0 = $realtime;
		@(negedge bclk) t1 = $realtime;
		@(posedge bclk) t2 = $realtime;
		chk(ac(t2 - t0), 32'(bp));
		chk(ac(t1 - t0), 32'(bp / 2));
		if (hi < frame) begin
			@(posedge fs) t0 = $realtime;
			@(negedge fs) t1 = $realtime;
			@(posedge fs) t2 = $realtime;
			chk(ac(t2 - t0), 32'(frame));
			chk(ac(t1 - t0), 32'(hi));
		end
	endtask
	task automatic data_scn;
		int b0;
		logic [31:0] st;
		apb(1'b1, OFF_TX, 32'ha5c3);
		cfg(32'h311);
		repeat (4) @(posedge fs);
		chk({16'h0, heard}, 32'ha5c3);
		chk({31'h0, sleep}, 32'h1);
		chk({31'h0, dout_oe_n}, 32'h0);
		apb(1'b1, OFF_GPIO, 32'h0);
		apb(1'b0, OFF_GPIO, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd & 32'h1, 32'h1);
		apb(1'b0, OFF_RX, 32'h0);
		chk(rd, 32'h3c5a);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd & 32'h1, 32'h0);
		chk(32'(mck > 0), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h211);
		repeat (4) @(posedge audio_clk);
		chk({31'h0, mclk}, 32'h0);
		cfg(32'h2b1);
		repeat (8) @(posedge audio_clk);
		chk({31'h0, sleep}, 32'h0);
		@(posedge fs);
		@(negedge bclk);
		b0 = bck;
		@(posedge fs);
		@(negedge bclk);
		chk(32'(bck - b0), 32'(GATE_BITS));
		cfg(32'h351);
		@(posedge fs);
		repeat (8) @(posedge pclk);
		apb(1'b0, OFF_STAT, 32'h0);
		st = rd;
		@(posedge fs);
		repeat (8) @(posedge pclk);
		apb(1'b0, OFF_STAT, 32'h0);
		chk((rd ^ st) & 32'h8, 32'h8);
		apb(1'b1, OFF_CTRL, 32'h200);
		repeat (40) @(posedge audio_clk);
		chk({29'h0, bclk, fs, dout}, 32'h0);
	endtask
	task automatic conclude;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#2400000;
		mismatches++;
		conclude();
	end
	initial begin
		// Three link clock cycles, so the link side sees reset as well.
		repeat (3) @(posedge audio_clk);
		@(posedge pclk);
		presetn <= 1'b1;
		regs_scn();
		for (int i = 0; i < 9; i++)
			rate_scn(CFGS[i], BPS[i]);
		data_scn();
		conclude();
	end
endmodule
